// [src/adcc_ctrl.sv]
// converter control: registers, source and reference decode, clock divider, start and busy sequencing
//
// Overview of operation
// - input source codes 000/100 pick the external channel, 001-011 supply /1 /2 /4, 101-111 internal ref /1 /2 /4.
// - an internal input source always disconnects the external channel path whatever channel is selected.
// - bits 4 and 3 of the input and clock select register read zero and ignore writes.
// - the conversion clock is the system clock divided by 1, 2, 4 up to 128 by the 3-bit divider code.
// - reference register bit 7 enables the reference gain amplifier, needed for internal reference use.
// - the bandgap is powered only when its enable bit or low-voltage detect or low-voltage reset is on.
// - reference register bit 5 selects the reference input pin function.
// - reference register bit 4 selects the reference output pin function.
// - ref codes 0000 supply, 0001-0100 external x1-x4, 1010-1100 bandgap x2-x4, 1001 reserved, others supply.
// - a bandgap-derived reference disconnects both supply and external reference paths.
// - each set bit n of the pin enable register makes its pin analog channel n.
// - pin enable bit 5 maps port A pin 6 to analog channel 5.
// - alignment 0 gives high byte result 11:4 and low 3:0, alignment 1 gives high 11:8 and low 7:0.
// - a conversion starts when software writes start high with enable set, then start low again.
// - busy sets when a conversion starts and clears on completion as the interrupt flag rises.
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
`include "adcc_defines.svh"
module adcc_ctrl #(
  parameter int CONV_TICKS = `ADCC_CONV_TICKS
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  input  wire logic [11:0]         core_result,
  output adcc_pkg::adcc_mux_t      mux,
  output logic [2:0]               ext_channel_sel,
  output logic                     conv_clk_en,
  output logic                     conversion_busy_flag,
  output logic                     ref_gain_amp_enable,
  output logic                     bandgap_power,
  output logic                     ref_input_pin_sel,
  output logic                     ref_output_pin_sel,
  output logic [7:0]               analog_pin_en,
  output logic [7:0]               port_dir_override,
  output logic [7:0]               pullup_disconnect,
  output logic [7:0]               result_high_byte,
  output logic [7:0]               result_low_byte,
  output logic                     irq
);
  // tick counter is 5 bits wide, so 1 to 32 ticks fit; the check allows only 1 to 31
  if (CONV_TICKS < 1 || CONV_TICKS > 31) begin : g_ticks_chk
    $error("CONV_TICKS out of range");
  end

  adcc_pkg::adcc_state_all_t s_q, s_d;
  logic [2:0] ext_sel_q, ext_sel_d;

  function automatic logic [6:0] div_limit(input logic [2:0] code);
    div_limit = 7'((8'h01 << code) - 8'h01);
  endfunction

  function automatic adcc_pkg::adcc_mux_t decode(input logic [7:0] inclk, input logic [7:0] refc);
    adcc_pkg::adcc_mux_t m;
    m = '0;
    unique case (inclk[7:5])
      3'h0, 3'h4: begin m.in_kind = adcc_pkg::ADCC_IN_EXT; m.in_div_log2 = 2'h0; end
      3'h1, 3'h2, 3'h3: begin m.in_kind = adcc_pkg::ADCC_IN_SUPPLY; m.in_div_log2 = 2'(inclk[6:5] - 2'h1); end
      default: begin m.in_kind = adcc_pkg::ADCC_IN_INTREF; m.in_div_log2 = 2'(inclk[6:5] - 2'h1); end
    endcase
    m.ext_path_on = (m.in_kind == adcc_pkg::ADCC_IN_EXT);
    unique case (refc[3:0])
      4'h1, 4'h2, 4'h3, 4'h4: begin m.ref_kind = adcc_pkg::ADCC_REF_EXT; m.ref_gain = refc[2:0]; end
      4'hA, 4'hB, 4'hC: begin m.ref_kind = adcc_pkg::ADCC_REF_BANDGAP; m.ref_gain = 3'(refc[2:0] - 3'h0); end
      4'h9: begin m.ref_kind = adcc_pkg::ADCC_REF_RESERVED; m.ref_gain = 3'h1; end
      default: begin m.ref_kind = adcc_pkg::ADCC_REF_SUPPLY; m.ref_gain = 3'h1; end
    endcase
    m.ref_supply_on = (m.ref_kind == adcc_pkg::ADCC_REF_SUPPLY);
    m.ref_ext_on = (m.ref_kind == adcc_pkg::ADCC_REF_EXT);
    return m;
  endfunction

  logic        acc_wr, acc_rd, done;
  logic [31:0] rd_word;

  always_comb begin
    acc_wr = psel && penable && pwrite && s_q.pready;
    // read word latched in setup so it stands during the access cycle
    acc_rd = psel && !penable && !pwrite;
    done   = (s_q.st == adcc_pkg::ADCC_ST_CONV) && conv_clk_en && (s_q.tick_cnt == 5'(CONV_TICKS - 1));
    rd_word = '0;
    unique case (paddr)
      `ADCC_OFF_CTRL: begin
        rd_word[`ADCC_CTRL_START]  = s_q.start;
        rd_word[`ADCC_CTRL_BUSY]   = (s_q.st == adcc_pkg::ADCC_ST_CONV);
        rd_word[`ADCC_CTRL_ENABLE] = s_q.enable;
        rd_word[`ADCC_CTRL_ALIGN]  = s_q.align;
      end
      `ADCC_OFF_INCLK: rd_word[7:0] = s_q.inclk & `ADCC_INCLK_WMASK;
      `ADCC_OFF_REF: rd_word[7:0] = s_q.refc;
      `ADCC_OFF_PINEN: rd_word[7:0] = s_q.pinen;
      `ADCC_OFF_RESULT: rd_word[11:0] = s_q.result;
      `ADCC_OFF_IRQ_STAT: rd_word[0] = s_q.irq_stat;
      `ADCC_OFF_IRQ_MASK: rd_word[0] = s_q.irq_mask;
      `ADCC_OFF_SYSCTL: begin
        rd_word[`ADCC_SYS_LVD] = s_q.lvd_en;
        rd_word[`ADCC_SYS_LVR] = s_q.lvr_en;
      end
      default: rd_word = '0;
    endcase
  end

  always_comb begin
    s_d = s_q;
    ext_sel_d = ext_sel_q;
    s_d.pready = psel && !penable;
    s_d.pslverr = 1'b0;
    if (acc_rd) begin
      s_d.prdata = rd_word;
    end
    if (psel && !penable) begin
      s_d.pslverr = !(paddr inside {`ADCC_OFF_CTRL, `ADCC_OFF_INCLK, `ADCC_OFF_REF, `ADCC_OFF_PINEN,
                                    `ADCC_OFF_RESULT, `ADCC_OFF_IRQ_STAT, `ADCC_OFF_IRQ_MASK, `ADCC_OFF_SYSCTL});
    end
    if (acc_wr && pstrb[0]) begin
      unique case (paddr)
        `ADCC_OFF_CTRL: begin
          s_d.start  = pwdata[`ADCC_CTRL_START];
          s_d.enable = pwdata[`ADCC_CTRL_ENABLE];
          s_d.align  = pwdata[`ADCC_CTRL_ALIGN];
          ext_sel_d  = pwdata[2:0];
        end
        `ADCC_OFF_INCLK: s_d.inclk = pwdata[7:0] & `ADCC_INCLK_WMASK;
        `ADCC_OFF_REF: s_d.refc = pwdata[7:0];
        `ADCC_OFF_PINEN: s_d.pinen = pwdata[7:0];
        `ADCC_OFF_IRQ_STAT: if (pwdata[0]) s_d.irq_stat = 1'b0;
        `ADCC_OFF_IRQ_MASK: s_d.irq_mask = pwdata[0];
        `ADCC_OFF_SYSCTL: begin
          s_d.lvd_en = pwdata[`ADCC_SYS_LVD];
          s_d.lvr_en = pwdata[`ADCC_SYS_LVR];
        end
        default: s_d.start = s_q.start;
      endcase
    end
    // conversion clock divider
    if (s_q.div_cnt >= div_limit(s_q.inclk[2:0])) begin
      s_d.div_cnt = '0;
    end else begin
      s_d.div_cnt = 7'(s_q.div_cnt + 7'h01);
    end
    unique case (s_q.st)
      adcc_pkg::ADCC_ST_IDLE: if (s_q.start && s_q.enable) s_d.st = adcc_pkg::ADCC_ST_ARMED;
      adcc_pkg::ADCC_ST_ARMED: begin
        if (!s_q.start) begin
          s_d.st = adcc_pkg::ADCC_ST_CONV;
          s_d.tick_cnt = '0;
        end
      end
      adcc_pkg::ADCC_ST_CONV: begin
        if (conv_clk_en) s_d.tick_cnt = 5'(s_q.tick_cnt + 5'h01);
        if (done) begin
          s_d.st = adcc_pkg::ADCC_ST_IDLE;
          s_d.result = core_result;
        end
      end
      default: s_d.st = adcc_pkg::ADCC_ST_IDLE;
    endcase
    if (done) s_d.irq_stat = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{st: adcc_pkg::ADCC_ST_IDLE, inclk: `ADCC_INCLK_RST, refc: `ADCC_REF_RST, pinen: `ADCC_PINEN_RST,
               lvd_en: 1'b0, lvr_en: 1'b0, default: '0};
      ext_sel_q <= 3'h0;
    end else begin
      s_q <= s_d;
      ext_sel_q <= ext_sel_d;
    end
  end

  always_comb begin
    pready  = s_q.pready;
    prdata  = s_q.prdata;
    pslverr = s_q.pslverr;
    mux = decode(s_q.inclk, s_q.refc);
    ext_channel_sel = ext_sel_q;
    conv_clk_en = (s_q.div_cnt >= div_limit(s_q.inclk[2:0]));
    conversion_busy_flag = (s_q.st == adcc_pkg::ADCC_ST_CONV);
    ref_gain_amp_enable = s_q.refc[`ADCC_REF_GAIN];
    bandgap_power = s_q.refc[`ADCC_REF_BGEN] || s_q.lvd_en || s_q.lvr_en;
    ref_input_pin_sel = s_q.refc[`ADCC_REF_INPIN];
    ref_output_pin_sel = s_q.refc[`ADCC_REF_OUTPIN];
    analog_pin_en = s_q.pinen;
    port_dir_override = s_q.pinen;
    pullup_disconnect = s_q.pinen;
    if (s_q.align) begin
      result_high_byte = {4'h0, s_q.result[11:8]};
      result_low_byte  = s_q.result[7:0];
    end else begin
      result_high_byte = s_q.result[11:4];
      result_low_byte  = {4'h0, s_q.result[3:0]};
    end
    irq = s_q.irq_stat && s_q.irq_mask;
  end

  // input source decode
  AST_EXT_OFF: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_q.inclk[5] || s_q.inclk[6] ? !mux.ext_path_on : mux.ext_path_on)
    else $error("external path wrong for source code");

  AST_SRC_EXT: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_q.inclk[7:5] inside {3'h0, 3'h4} |-> mux.in_kind == adcc_pkg::ADCC_IN_EXT && mux.in_div_log2 == 2'h0)
    else $error("external source code decoded wrong");

  AST_SRC_SUPPLY: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_q.inclk[7:5] inside {3'h1, 3'h2, 3'h3} |-> mux.in_kind == adcc_pkg::ADCC_IN_SUPPLY)
    else $error("supply source code decoded wrong");

  AST_SRC_INTREF: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_q.inclk[7:5] inside {3'h5, 3'h6, 3'h7} |-> mux.in_kind == adcc_pkg::ADCC_IN_INTREF)
    else $error("internal reference source code decoded wrong");

  // register access
  AST_UNIMPL_ZERO: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_q.inclk[4:3] == 2'h0)
    else $error("unimplemented bits not zero");

  AST_INCLK_WR: assert property (
    @(posedge pclk) disable iff (!presetn)
    acc_wr && pstrb[0] && paddr == `ADCC_OFF_INCLK |=> s_q.inclk == ($past(pwdata[7:0]) & `ADCC_INCLK_WMASK))
    else $error("input and clock select write wrong");

  AST_READY_SETUP: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready)
    else $error("no ready in first access cycle");

  AST_READY_PULSE: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held longer than one cycle");

  AST_SLVERR_READY: assert property (
    @(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error response without ready");

  AST_RD_PINEN: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && penable && !pwrite && pready && paddr == `ADCC_OFF_PINEN |-> prdata[7:0] == s_q.pinen)
    else $error("pin enable read data not standing at ready");

  // conversion clock
  AST_DIV_ONE: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_q.inclk[2:0] == 3'h0 |-> conv_clk_en)
    else $error("divide by one not every cycle");

  AST_DIV_GAP: assert property (
    @(posedge pclk) disable iff (!presetn)
    conv_clk_en && s_q.inclk[2:0] != 3'h0 ##1 s_q.inclk[2:0] != 3'h0 |-> !conv_clk_en)
    else $error("divided clock enable longer than one cycle");

  // reference decode
  AST_REF_EXT: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_q.refc[3:0] inside {4'h1, 4'h2, 4'h3, 4'h4} |->
      mux.ref_kind == adcc_pkg::ADCC_REF_EXT && mux.ref_gain == s_q.refc[2:0] && mux.ref_ext_on)
    else $error("external reference code decoded wrong");

  AST_REF_BG: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_q.refc[3:0] inside {4'hA, 4'hB, 4'hC} |->
      mux.ref_kind == adcc_pkg::ADCC_REF_BANDGAP && mux.ref_gain == s_q.refc[2:0])
    else $error("bandgap reference code decoded wrong");

  AST_REF_SUPPLY: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(s_q.refc[3:0] inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h9, 4'hA, 4'hB, 4'hC}) |->
      mux.ref_kind == adcc_pkg::ADCC_REF_SUPPLY && mux.ref_supply_on)
    else $error("supply reference code decoded wrong");

  AST_BG_DISC: assert property (
    @(posedge pclk) disable iff (!presetn)
    mux.ref_kind == adcc_pkg::ADCC_REF_BANDGAP |-> !mux.ref_supply_on && !mux.ref_ext_on)
    else $error("bandgap ref leaves a path on");

  AST_BG_POWER: assert property (
    @(posedge pclk) disable iff (!presetn)
    bandgap_power == (s_q.refc[`ADCC_REF_BGEN] | s_q.lvd_en | s_q.lvr_en))
    else $error("bandgap power wrong");

  // start and busy sequencing
  AST_START_SEQ: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_q.st == adcc_pkg::ADCC_ST_ARMED && !s_q.start |=> conversion_busy_flag)
    else $error("conversion not started on fall of start");

  AST_NO_START: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_q.st == adcc_pkg::ADCC_ST_IDLE |=> !conversion_busy_flag)
    else $error("conversion started without high then low start");

  AST_DONE_IRQ: assert property (
    @(posedge pclk) disable iff (!presetn)
    $fell(conversion_busy_flag) |-> s_q.irq_stat)
    else $error("busy fell without interrupt flag");

  AST_DONE_END: assert property (
    @(posedge pclk) disable iff (!presetn)
    done |=> !conversion_busy_flag && s_q.irq_stat && s_q.result == $past(core_result))
    else $error("conversion end not taken");

  // result split and pins
  AST_ALIGN: assert property (
    @(posedge pclk) disable iff (!presetn)
    !s_q.align |-> {result_high_byte, result_low_byte[3:0]} == s_q.result)
    else $error("alignment split wrong");

  AST_ALIGN_ONE: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_q.align |-> {result_high_byte, result_low_byte} == {4'h0, s_q.result})
    else $error("right alignment split wrong");

  AST_PIN_OVR: assert property (
    @(posedge pclk) disable iff (!presetn)
    pullup_disconnect == analog_pin_en && port_dir_override == analog_pin_en)
    else $error("pin override mismatch");

  COV_CONV: cover property (@(posedge pclk) disable iff (!presetn) $fell(conversion_busy_flag));
  COV_IRQ: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
  COV_BG_REF: cover property (@(posedge pclk) disable iff (!presetn) mux.ref_kind == adcc_pkg::ADCC_REF_BANDGAP);
  COV_START: cover property (@(posedge pclk) disable iff (!presetn) $rose(conversion_busy_flag));
  COV_SLVERR: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
endmodule // adcc_ctrl

// [src/adcc_defines.svh]
// register offsets, field positions, reset values and timing counts for the converter control block
`ifndef ADCC_DEFINES_SVH
`define ADCC_DEFINES_SVH
`define ADCC_OFF_CTRL      12'h000
`define ADCC_OFF_INCLK     12'h004
`define ADCC_OFF_REF       12'h008
`define ADCC_OFF_PINEN     12'h00C
`define ADCC_OFF_RESULT    12'h010
`define ADCC_OFF_IRQ_STAT  12'h014
`define ADCC_OFF_IRQ_MASK  12'h018
`define ADCC_OFF_SYSCTL    12'h01C
`define ADCC_INCLK_WMASK   8'hE7
`define ADCC_INCLK_RST     8'h00
`define ADCC_REF_RST       8'h00
`define ADCC_PINEN_RST     8'hFF
`define ADCC_CTRL_START    7
`define ADCC_CTRL_BUSY     6
`define ADCC_CTRL_ENABLE   5
`define ADCC_CTRL_ALIGN    4
`define ADCC_SYS_LVD       0
`define ADCC_SYS_LVR       1
`define ADCC_REF_GAIN      7
`define ADCC_REF_BGEN      6
`define ADCC_REF_INPIN     5
`define ADCC_REF_OUTPIN    4
`define ADCC_CONV_TICKS    16
`endif

// [src/adcc_pkg.sv]
// types shared by the converter control block
package adcc_pkg;
  typedef enum logic [1:0] {ADCC_IN_EXT, ADCC_IN_SUPPLY, ADCC_IN_INTREF} adcc_in_kind_t;
  typedef enum logic [1:0] {ADCC_REF_SUPPLY, ADCC_REF_EXT, ADCC_REF_BANDGAP, ADCC_REF_RESERVED} adcc_ref_kind_t;
  typedef enum logic [1:0] {ADCC_ST_IDLE, ADCC_ST_ARMED, ADCC_ST_CONV} adcc_state_t;
  typedef struct packed {
    adcc_in_kind_t in_kind;
    logic [1:0]    in_div_log2;
    logic          ext_path_on;
    adcc_ref_kind_t ref_kind;
    logic [2:0]    ref_gain;
    logic          ref_supply_on;
    logic          ref_ext_on;
  } adcc_mux_t;
  typedef struct packed {
    adcc_state_t st;
    logic [7:0]  inclk;
    logic [7:0]  refc;
    logic [7:0]  pinen;
    logic        start;
    logic        enable;
    logic        align;
    logic        lvd_en;
    logic        lvr_en;
    logic        irq_stat;
    logic        irq_mask;
    logic [6:0]  div_cnt;
    logic [4:0]  tick_cnt;
    logic [11:0] result;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } adcc_state_all_t;
endpackage

// [sim/adcc_core_model.sv]
// converter core model answering with a result
`timescale 1ns/1ns
module adcc_core_model (
  input  wire logic        pclk,
  input  wire logic        busy,
  input  wire logic [11:0] val,
  output logic [11:0]      core_result
);
  // result stands while busy, inverted otherwise
  always_ff @(posedge pclk) begin
    core_result <= busy ? val : ~val;
  end
endmodule // adcc_core_model

// [sim/adcc_ctrl_tb.sv]
// testbench for the converter control block
`timescale 1ns/1ns
`include "adcc_defines.svh"
module adcc_ctrl_tb;
  localparam int BGS = 20;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000, val = 12'hA5C, core_result;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, er, conv_clk_en, conversion_busy_flag, ref_gain_amp_enable;
  logic bandgap_power, ref_input_pin_sel, ref_output_pin_sel, irq;
  adcc_pkg::adcc_mux_t mux;
  logic [2:0] ext_channel_sel;
  logic [7:0] analog_pin_en, port_dir_override, pullup_disconnect, result_high_byte, result_low_byte;
  int errors = 0, cmp_count = 0;
  always #4 pclk = ~pclk;
  adcc_ctrl u_adcc_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
    .prdata, .pslverr, .core_result, .mux, .ext_channel_sel, .conv_clk_en, .conversion_busy_flag,
    .ref_gain_amp_enable, .bandgap_power, .ref_input_pin_sel, .ref_output_pin_sel, .analog_pin_en,
    .port_dir_override, .pullup_disconnect, .result_high_byte, .result_low_byte, .irq);
  adcc_core_model u_adcc_core_model (.pclk, .busy(conversion_busy_flag), .val, .core_result);
  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) errors++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task t_regs;
    rdchk(`ADCC_OFF_INCLK, 32'h0);
    rdchk(`ADCC_OFF_REF, 32'h0);
    rdchk(`ADCC_OFF_PINEN, 32'hFF);
    wr(`ADCC_OFF_INCLK, 8'hFF);
    rdchk(`ADCC_OFF_INCLK, 32'hE7);
    chk({31'h0, er}, 32'h0);
    pstrb <= 4'h0;
    wr(`ADCC_OFF_PINEN, 8'h00);
    pstrb <= 4'hF;
    rdchk(`ADCC_OFF_PINEN, 32'hFF);
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, er}, 32'h1);
    $display("test regs done");
  endtask
  task t_insrc;
    adcc_pkg::adcc_in_kind_t k;
    logic [1:0] dv;
    wr(`ADCC_OFF_CTRL, 8'h27);
    for (int i = 0; i < 8; i++) begin
      wr(`ADCC_OFF_INCLK, 8'(i << 5));
      @(posedge pclk);
      k = (i % 4 == 0) ? adcc_pkg::ADCC_IN_EXT : (i > 4) ? adcc_pkg::ADCC_IN_INTREF : adcc_pkg::ADCC_IN_SUPPLY;
      dv = (i % 4 == 0) ? 2'h0 : 2'(i % 4 - 1);
      chk(32'({mux.in_kind, mux.in_div_log2, mux.ext_path_on}), 32'({k, dv, k == adcc_pkg::ADCC_IN_EXT}));
      chk(32'(ext_channel_sel), 32'h7);
    end
    $display("test input source done");
  endtask
  task t_clkdiv;
    int n;
    for (int c = 0; c < 8; c++) begin
      wr(`ADCC_OFF_INCLK, 8'(c));
      n = 0;
      repeat (256) begin
        @(posedge pclk);
        n += int'(conv_clk_en === 1'b1);
      end
      chk(32'(n), 32'(256 >> c));
    end
    $display("test clock divider done");
  endtask
  task t_ref;
    adcc_pkg::adcc_ref_kind_t k;
    logic s, x;
    for (int i = 0; i < 16; i++) begin
      wr(`ADCC_OFF_REF, {i[0], 1'b0, i[1], i[2], i[3:0]});
      @(posedge pclk);
      k = adcc_pkg::ADCC_REF_SUPPLY;
      if (i >= 1 && i <= 4) k = adcc_pkg::ADCC_REF_EXT;
      if (i == 9) k = adcc_pkg::ADCC_REF_RESERVED;
      if (i >= 10 && i <= 12) k = adcc_pkg::ADCC_REF_BANDGAP;
      s = (k == adcc_pkg::ADCC_REF_SUPPLY);
      x = (k == adcc_pkg::ADCC_REF_EXT);
      chk(32'({mux.ref_kind, mux.ref_supply_on, mux.ref_ext_on}), 32'({k, s, x}));
      if (x || k == adcc_pkg::ADCC_REF_BANDGAP) chk(32'(mux.ref_gain), 32'(i % 8));
      chk(32'({ref_gain_amp_enable, ref_input_pin_sel, ref_output_pin_sel}), 32'({i[0], i[1], i[2]}));
    end
    for (int i = 0; i < 8; i++) begin
      wr(`ADCC_OFF_REF, {1'b0, i[0], 6'h0});
      wr(`ADCC_OFF_SYSCTL, {6'h0, i[2], i[1]});
      @(posedge pclk);
      chk(32'(bandgap_power), 32'(i != 0));
    end
    $display("test reference done");
  endtask
  task t_pins;
    wr(`ADCC_OFF_PINEN, 8'h20);
    @(posedge pclk);
    chk(32'({analog_pin_en, port_dir_override, pullup_disconnect}), 32'h202020);
    rdchk(`ADCC_OFF_PINEN, 32'h20);
    $display("test pins done");
  endtask
  task t_conv;
    int n;
    wr(`ADCC_OFF_INCLK, 8'h00);
    wr(`ADCC_OFF_IRQ_MASK, 8'h01);
    wr(`ADCC_OFF_REF, 8'hC0);
    repeat (BGS) @(posedge pclk);
    wr(`ADCC_OFF_CTRL, 8'hA0);
    wr(`ADCC_OFF_CTRL, 8'h20);
    n = 0;
    while (conversion_busy_flag !== 1'b1 && n < 10) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(conversion_busy_flag), 32'h1);
    rdchk(`ADCC_OFF_CTRL, 32'h60);
    n = 0;
    while (conversion_busy_flag !== 1'b0 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    @(posedge pclk);
    chk(32'({conversion_busy_flag, irq}), 32'h1);
    rdchk(`ADCC_OFF_IRQ_STAT, 32'h1);
    chk(32'(result_high_byte), 32'(val[11:4]));
    rdchk(`ADCC_OFF_RESULT, 32'(val));
    wr(`ADCC_OFF_CTRL, 8'h30);
    @(posedge pclk);
    chk(32'({result_high_byte, result_low_byte}), 32'(val));
    wr(`ADCC_OFF_IRQ_STAT, 8'h01);
    @(posedge pclk);
    chk(32'(irq), 32'h0);
    $display("test conversion done");
  endtask
  task end_of_test;
    $display("comparisons=%0d errors=%0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #80000;
    errors++;
    end_of_test;
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_insrc;
    t_clkdiv;
    t_ref;
    t_pins;
    t_conv;
    end_of_test;
  end
endmodule // adcc_ctrl_tb
